// *** tcc_pkg.sv ***
// Constants, register map and enumerations of the capture/compare timer.
// Assumes a single 20 MHz clock; the peripheral clock runs at half of it.
package tcc_pkg;

  // Register byte addresses as printed
  localparam logic [15:0] ADDR_COUNT     = 16'hFF12;
  localparam logic [15:0] ADDR_CC_FIRST  = 16'hFF14;
  localparam logic [15:0] ADDR_CC_SECOND = 16'hFF16;
  localparam logic [15:0] ADDR_MODE      = 16'hFF60;
  localparam logic [15:0] ADDR_PRESCALE  = 16'hFF61;
  localparam logic [15:0] ADDR_CC_CTRL   = 16'hFF62;

  // Mode control fields
  localparam int OVF_BIT      = 0;
  localparam int OUT_TIME_BIT = 1;
  localparam int MODE_LO_BIT  = 2;
  localparam int MODE_HI_BIT  = 3;

  // Prescaler/edge fields
  localparam int CLK_SEL_LO   = 0;
  localparam int CLK_SEL_HI   = 1;
  localparam int EDGE0_LO_BIT = 4;
  localparam int EDGE0_HI_BIT = 5;
  localparam int EDGE1_LO_BIT = 6;
  localparam int EDGE1_HI_BIT = 7;

  // Capture/compare control fields
  localparam int ROLE_FIRST_BIT  = 0;
  localparam int TRIG_FIRST_BIT  = 1;
  localparam int ROLE_SECOND_BIT = 2;

  // Reset values and counter constants
  localparam logic [15:0] RST_CC    = 16'h0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [1:0]  RST_FIELD = 2'h0;
  localparam logic        RST_BIT   = 1'b0;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // Count clock timing
  localparam int CLK_HZ  = 20000000;
  localparam int FXP_HZ  = 10000000;
  localparam int FXP_CYC = CLK_HZ / FXP_HZ;
  localparam logic [9:0] DIV_FXP    = 10'(FXP_CYC * 1);
  localparam logic [9:0] DIV_FXP4   = 10'(FXP_CYC * 4);
  localparam logic [9:0] DIV_FXP256 = 10'(FXP_CYC * 256);
  localparam logic [9:0] DIV_ONE    = 10'h001;

  typedef enum logic [1:0] {
    MODE_STOP      = 2'h0,
    MODE_FREE      = 2'h1,
    MODE_CLR_EDGE  = 2'h2,
    MODE_CLR_MATCH = 2'h3
  } tcc_mode_t;

  typedef enum logic [1:0] {
    CLK_FXP    = 2'h0,
    CLK_FXP4   = 2'h1,
    CLK_FXP256 = 2'h2,
    CLK_EXT    = 2'h3
  } tcc_clk_t;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_NONE = 2'h2,
    EDGE_BOTH = 2'h3
  } tcc_edge_t;

  // Gray along idle -> wait fall -> wait rise
  typedef enum logic [1:0] {
    CAP_IDLE = 2'h0,
    CAP_FALL = 2'h1,
    CAP_RISE = 2'h3
  } tcc_cap_t;

endpackage

// *** tcc_edge_det.sv ***
// Pin synchroniser with edge detection for one timer input.
// Assumes the pin is asynchronous to clk; pulses appear two edges late.
module tcc_edge_det (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  logic syncA;
  logic syncB;
  logic syncC;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      syncC <= 1'b0;
    end else begin
      syncA <= pin;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  // Only the settled stages feed the detector
  assign rise = syncB & ~syncC;
  assign fall = ~syncB & syncC;

endmodule // tcc_edge_det

// *** tcc_timer.sv ***
// 16-bit timer core: counter, second capture/compare register, mode control.
// Assumes a plain register port with read data one cycle after the strobe.
//
// How it works
// [RULE_01] Counter increments on each count-clock rise while running.
// [RULE_02] Compare role: match of second register and counter raises its request.
// [RULE_03] Control bit 2 selects capture role, otherwise compare role.
// [RULE_04] Capture latches counter on first-input valid edge; 00 fall, 01 rise, 11 both.
// [RULE_05] Software never programs edge select 10.
// [RULE_06] Second register zero: request as counter steps 0000H to 0001H.
// [RULE_07] Lowered compare value: counter wraps through overflow; software restarts.
// [RULE_08] Second register content after stop is not defined.
// [RULE_09] Compare role ignores capture triggers.
// [RULE_10] Capture wins over a coinciding read or stop.
// [RULE_11] Nonzero mode bits start the counter; 00 stops and clears it.
// [RULE_12] Mode 01 free-run, 10 clear on input edge, 11 clear on first match.
// [RULE_13] Output toggles on matches, also on input edge when timing bit set.
// [RULE_14] Requests follow role: matches in compare, edges in capture, none stopped.
// [RULE_15] Overflow flag sets on FFFFH to 0000H wrap in listed modes.
// [RULE_16] Clearing overflow before next count clock has no effect.
// [RULE_17] Software stops the timer before writing mode bits other than overflow.
// [RULE_18] Stopped timer neither counts nor raises requests.
// [RULE_19] Software stops the timer before clock-stopping low-power modes.
// [RULE_20] Software sets first-input edge bits only while stopped.
// [RULE_21] Capture on count-clock fall, request on the following rise.
// [RULE_22] Overflow flag stays set until software writes zero.
//
// Implementation choice: the plain strobed port.
module tcc_timer (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic        timerInputFirst,
  input  wire logic        timerInputSecond,
  output logic      [15:0] rdata,
  output logic             matchIrqFirst,
  output logic             matchIrqSecond,
  output logic             timerOutputPin
);

  // Register state
  logic [15:0]         captureCompareFirst;
  logic [15:0]         captureCompareSecond;
  logic [15:0]         countRegister;
  tcc_pkg::tcc_mode_t  modeSel;
  logic                outputTimingSel;
  logic                overflowFlag;
  tcc_pkg::tcc_clk_t   clkSel;
  tcc_pkg::tcc_edge_t  firstEdgeSel;
  tcc_pkg::tcc_edge_t  secondEdgeSel;
  logic                firstRoleSelect;
  logic                firstTrigSelect;
  logic                secondRoleSelect;

  // Internal state
  logic [9:0]          divCount;
  logic                ovfWindow;
  logic                clrPending;
  tcc_pkg::tcc_cap_t   capState;
  tcc_pkg::tcc_cap_t   next_capState;

  // Pin edges
  logic [1:0]          pinRaw;
  logic [1:0]          pinRise;
  logic [1:0]          pinFall;

  assign pinRaw = {timerInputSecond, timerInputFirst};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      tcc_edge_det u_edge (
        .clk    (clk),
        .resetn (resetn),
        .pin    (pinRaw[gi]),
        .rise   (pinRise[gi]),
        .fall   (pinFall[gi])
      );
    end
  endgenerate

  // The prohibited selection decodes to no edge at all
  function automatic logic edgeHit(input tcc_pkg::tcc_edge_t sel, input logic r,
                                   input logic f);
    edgeHit = ((sel == tcc_pkg::EDGE_RISE) && r) || ((sel == tcc_pkg::EDGE_FALL) && f) ||
              ((sel == tcc_pkg::EDGE_BOTH) && (r || f)); // [RULE_04] [RULE_05]
  endfunction

  // Decode
  wire running   = (modeSel != tcc_pkg::MODE_STOP); // [RULE_11]
  wire edgeFirst = edgeHit(firstEdgeSel, pinRise[0], pinFall[0]);
  wire edgeSecond = edgeHit(secondEdgeSel, pinRise[1], pinFall[1]);
  wire extClock  = (clkSel == tcc_pkg::CLK_EXT);

  wire [9:0] divPeriod = (clkSel == tcc_pkg::CLK_FXP)  ? tcc_pkg::DIV_FXP :
                         (clkSel == tcc_pkg::CLK_FXP4) ? tcc_pkg::DIV_FXP4 :
                         tcc_pkg::DIV_FXP256;
  wire [9:0] divLast   = divPeriod - tcc_pkg::DIV_ONE;
  wire [9:0] divHalf   = (divPeriod >> 1) - tcc_pkg::DIV_ONE;

  // External count clock has no separate fall, so capture and count share the tick
  wire countRise = running && (extClock ? edgeFirst : (divCount == divLast));
  wire countFall = running && (extClock ? edgeFirst : (divCount == divHalf));

  wire atFirst   = (countRegister == captureCompareFirst);
  wire atSecond  = (countRegister == captureCompareSecond);
  // Match is seen as the counter leaves the value, so a zero compare fires at 0001H
  wire hitFirst  = countRise && !firstRoleSelect && atFirst;
  wire hitSecond = countRise && !secondRoleSelect && atSecond; // [RULE_02] [RULE_06]

  wire clrMatch  = countRise && (modeSel == tcc_pkg::MODE_CLR_MATCH) && atFirst; // [RULE_12]
  wire clrEdge   = countRise && (modeSel == tcc_pkg::MODE_CLR_EDGE) && clrPending; // [RULE_12]
  wire wrapNow   = countRise && (countRegister == tcc_pkg::COUNT_MAX) && !clrMatch;
  wire ovfMode   = (modeSel == tcc_pkg::MODE_CLR_EDGE) || (modeSel == tcc_pkg::MODE_CLR_MATCH) ||
                   (captureCompareFirst == tcc_pkg::COUNT_MAX);
  wire ovfSet    = wrapNow && ovfMode; // [RULE_15]

  wire capTake   = (capState == tcc_pkg::CAP_FALL) && countFall; // [RULE_21]
  wire capIrq    = (capState == tcc_pkg::CAP_RISE) && countRise; // [RULE_21]

  // Bus decode
  wire wrCcFirst  = wr && (addr == tcc_pkg::ADDR_CC_FIRST);
  wire wrCcSecond = wr && (addr == tcc_pkg::ADDR_CC_SECOND);
  wire wrMode     = wr && (addr == tcc_pkg::ADDR_MODE);
  wire wrPrescale = wr && (addr == tcc_pkg::ADDR_PRESCALE);
  wire wrCcCtrl   = wr && (addr == tcc_pkg::ADDR_CC_CTRL);

  wire [15:0] modeRead = {12'h000, modeSel, outputTimingSel, overflowFlag};
  wire [15:0] prescaleRead = {8'h00, secondEdgeSel, firstEdgeSel, 2'h0, clkSel};
  wire [15:0] ctrlRead = {13'h0000, secondRoleSelect, firstTrigSelect, firstRoleSelect};
  wire [15:0] readMux =
    (addr == tcc_pkg::ADDR_COUNT)     ? countRegister :
    (addr == tcc_pkg::ADDR_CC_FIRST)  ? captureCompareFirst :
    (addr == tcc_pkg::ADDR_CC_SECOND) ? captureCompareSecond :
    (addr == tcc_pkg::ADDR_MODE)      ? modeRead :
    (addr == tcc_pkg::ADDR_PRESCALE)  ? prescaleRead :
    (addr == tcc_pkg::ADDR_CC_CTRL)   ? ctrlRead : 16'h0000;

  // Next values
  wire [15:0] next_count =
    !running              ? tcc_pkg::RST_COUNT :                  // [RULE_11] [RULE_18]
    (clrEdge || clrMatch) ? tcc_pkg::RST_COUNT :
    countRise             ? countRegister + tcc_pkg::COUNT_ONE :  // [RULE_01] [RULE_07]
    countRegister;

  // A capture in the same cycle as a write or read keeps the captured count
  wire [15:0] next_ccSecond = capTake    ? countRegister :        // [RULE_04] [RULE_10]
                              wrCcSecond ? wdata : captureCompareSecond; // [RULE_08] Kept on stop

  // Set wins over the software clear, and the window repeats it until the next tick
  wire next_overflow = ovfSet || ovfWindow ? 1'b1 :                // [RULE_16]
                       (wrMode && !wdata[tcc_pkg::OVF_BIT]) ? 1'b0 : overflowFlag; // [RULE_22]
  wire next_ovfWindow = ovfSet || (ovfWindow && !countRise && running);

  wire next_clrPending = running && ((edgeFirst && modeSel == tcc_pkg::MODE_CLR_EDGE) ||
                                     (clrPending && !countRise));

  wire next_irqSecond = hitSecond || capIrq; // [RULE_14]
  wire next_irqFirst  = hitFirst || (running && firstRoleSelect && edgeSecond); // [RULE_14]
  wire outToggle      = running &&
                        (hitFirst || hitSecond || (outputTimingSel && edgeFirst)); // [RULE_13]

  wire [9:0] next_div = (!running || extClock || divCount == divLast) ? 10'h000 :
                        divCount + tcc_pkg::DIV_ONE;

  always_comb begin
    next_capState = capState;
    case (capState)
      tcc_pkg::CAP_IDLE: begin
        if (running && secondRoleSelect && edgeFirst) begin // [RULE_03] [RULE_09]
          next_capState = tcc_pkg::CAP_FALL;
        end
      end
      tcc_pkg::CAP_FALL: begin
        if (!running) begin
          next_capState = tcc_pkg::CAP_IDLE;
        end else if (countFall) begin
          next_capState = tcc_pkg::CAP_RISE;
        end
      end
      tcc_pkg::CAP_RISE: begin
        if (!running || countRise) begin
          next_capState = tcc_pkg::CAP_IDLE;
        end
      end
      default: next_capState = tcc_pkg::CAP_IDLE;
    endcase
  end

  // Configuration writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      modeSel          <= tcc_pkg::MODE_STOP;
      outputTimingSel  <= tcc_pkg::RST_BIT;
      clkSel           <= tcc_pkg::CLK_FXP;
      firstEdgeSel     <= tcc_pkg::EDGE_FALL;
      secondEdgeSel    <= tcc_pkg::EDGE_FALL;
      firstRoleSelect  <= tcc_pkg::RST_BIT;
      firstTrigSelect  <= tcc_pkg::RST_BIT;
      secondRoleSelect <= tcc_pkg::RST_BIT;
      captureCompareFirst <= tcc_pkg::RST_CC;
    end else begin
      if (wrMode) begin
        modeSel         <= tcc_pkg::tcc_mode_t'(wdata[tcc_pkg::MODE_HI_BIT:tcc_pkg::MODE_LO_BIT]);
        outputTimingSel <= wdata[tcc_pkg::OUT_TIME_BIT];
      end
      if (wrPrescale) begin
        clkSel        <= tcc_pkg::tcc_clk_t'(wdata[tcc_pkg::CLK_SEL_HI:tcc_pkg::CLK_SEL_LO]);
        firstEdgeSel  <= tcc_pkg::tcc_edge_t'(wdata[tcc_pkg::EDGE0_HI_BIT:tcc_pkg::EDGE0_LO_BIT]);
        secondEdgeSel <= tcc_pkg::tcc_edge_t'(wdata[tcc_pkg::EDGE1_HI_BIT:tcc_pkg::EDGE1_LO_BIT]);
      end
      if (wrCcCtrl) begin
        firstRoleSelect  <= wdata[tcc_pkg::ROLE_FIRST_BIT];
        firstTrigSelect  <= wdata[tcc_pkg::TRIG_FIRST_BIT];
        secondRoleSelect <= wdata[tcc_pkg::ROLE_SECOND_BIT];
      end
      if (wrCcFirst) begin
        captureCompareFirst <= wdata;
      end
    end
  end

  // Counting and events
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      countRegister        <= tcc_pkg::RST_COUNT;
      captureCompareSecond <= tcc_pkg::RST_CC;
      overflowFlag         <= tcc_pkg::RST_BIT;
      ovfWindow            <= tcc_pkg::RST_BIT;
      clrPending           <= tcc_pkg::RST_BIT;
      capState             <= tcc_pkg::CAP_IDLE;
      divCount             <= 10'h000;
    end else begin
      countRegister        <= next_count;
      captureCompareSecond <= next_ccSecond;
      overflowFlag         <= next_overflow;
      ovfWindow            <= next_ovfWindow;
      clrPending           <= next_clrPending;
      capState             <= next_capState;
      divCount             <= next_div;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata          <= 16'h0000;
      matchIrqFirst  <= 1'b0;
      matchIrqSecond <= 1'b0;
      timerOutputPin <= 1'b0;
    end else begin
      rdata          <= rd ? readMux : 16'h0000;
      matchIrqFirst  <= next_irqFirst;
      matchIrqSecond <= next_irqSecond;
      timerOutputPin <= timerOutputPin ^ outToggle;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_fallTick;
    (capState == tcc_pkg::CAP_FALL) && countFall;
  endsequence

  sequence s_captured;
    (captureCompareSecond == $past(countRegister)) && (capState == tcc_pkg::CAP_RISE);
  endsequence

  property p_countInc;
    countRise && !clrMatch && !clrEdge |=> countRegister == 16'($past(countRegister) + 16'h0001);
  endproperty
  a_countInc: assert property (p_countInc) else $error("counter did not step"); // [RULE_01]

  property p_cmpIrq;
    countRise && !secondRoleSelect && atSecond |=> matchIrqSecond;
  endproperty
  a_cmpIrq: assert property (p_cmpIrq) else $error("compare match request missing"); // [RULE_02]

  property p_noCapInCompare;
    !secondRoleSelect && (capState == tcc_pkg::CAP_IDLE) |=> capState == tcc_pkg::CAP_IDLE;
  endproperty
  a_noCapInCompare: assert property (p_noCapInCompare) else $error("capture in compare role"); // [RULE_09]

  property p_capture;
    s_fallTick |=> s_captured;
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong"); // [RULE_04]

  property p_capIrq;
    s_fallTick ##1 (countRise && capState == tcc_pkg::CAP_RISE) |=> matchIrqSecond;
  endproperty
  a_capIrq: assert property (p_capIrq) else $error("capture request not on rise"); // [RULE_21]

  property p_stopped;
    !running |=> (countRegister == 16'h0000) && !matchIrqSecond && !matchIrqFirst;
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped timer active"); // [RULE_18]

  property p_clrMatch;
    countRise && (modeSel == tcc_pkg::MODE_CLR_MATCH) && atFirst |=> countRegister == 16'h0000;
  endproperty
  a_clrMatch: assert property (p_clrMatch) else $error("match clear missing"); // [RULE_12]

  property p_ovfSet;
    wrapNow && ovfMode |=> overflowFlag [*2];
  endproperty
  a_ovfSet: assert property (p_ovfSet) else $error("overflow flag not set"); // [RULE_15]

  property p_ovfReset;
    ovfWindow && running |=> overflowFlag;
  endproperty
  a_ovfReset: assert property (p_ovfReset) else $error("early clear of overflow took effect"); // [RULE_16]

  property p_ovfSticky;
    overflowFlag && !wrMode |=> overflowFlag;
  endproperty
  a_ovfSticky: assert property (p_ovfSticky) else $error("overflow flag dropped"); // [RULE_22]

  property p_outHold;
    !running ##1 !running |-> $stable(timerOutputPin);
  endproperty
  a_outHold: assert property (p_outHold) else $error("output changed while stopped"); // [RULE_13]

endmodule // tcc_timer

// *** tcc_pin_model.sv ***
// Far-side model: drives both timer input pins like an outside signal source.
// Assumes the pins are sampled by the design's own synchroniser, asynchronously.
module tcc_pin_model (
  input  wire logic clk,
  output logic      timerInputFirst,
  output logic      timerInputSecond
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    timerInputFirst  = 1'b0;
    timerInputSecond = 1'b0;
  end

  // Pin changes land mid-cycle, off any clock edge, as a real outside source would
  task automatic set_pin(input int which, input logic level, input int holdCycles);
    @(posedge clk);
    #17;
    if (which == 0) timerInputFirst = level;
    else timerInputSecond = level;
    // Level held for holdCycles clocks; the capture calls pass 40, twenty count-clock cycles
    repeat (holdCycles) @(posedge clk);
  endtask
endmodule // tcc_pin_model

// *** tb.sv ***
// Self-checking bench for the capture/compare timer core.
// Assumes the plain register port and the pin model on both timer inputs.
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        resetn;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic        timerInputFirst;
  logic        timerInputSecond;
  logic [15:0] rdata;
  logic        matchIrqFirst;
  logic        matchIrqSecond;
  logic        timerOutputPin;
  logic [15:0] valA;
  logic [15:0] valB;
  int          badCount;
  int          cmpCount;
  int          irqSecondSeen;
  int          irqFirstSeen;
  int          cycles;
  tcc_pkg::tcc_edge_t edgeCodes [3];
  int          edgeIrqs [3];

  tcc_timer i_tcc_timer (
    .clk              (clk),
    .resetn           (resetn),
    .addr             (addr),
    .wdata            (wdata),
    .wr               (wr),
    .rd               (rd),
    .timerInputFirst  (timerInputFirst),
    .timerInputSecond (timerInputSecond),
    .rdata            (rdata),
    .matchIrqFirst    (matchIrqFirst),
    .matchIrqSecond   (matchIrqSecond),
    .timerOutputPin   (timerOutputPin)
  );

  tcc_pin_model i_tcc_pin_model (
    .clk              (clk),
    .timerInputFirst  (timerInputFirst),
    .timerInputSecond (timerInputSecond)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Requests are single-cycle pulses, so a plain edge count matches the pulse count
  always @(posedge clk) begin
    if (matchIrqSecond === 1'b1) irqSecondSeen++;
    if (matchIrqFirst === 1'b1) irqFirstSeen++;
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      $display("wrong value at %0t: run did not finish in time", $time);
      tally_and_finish();
    end
  end

  function automatic logic [15:0] mode_word(input tcc_pkg::tcc_mode_t m);
    return {12'h000, m, 2'h0};
  endfunction

  task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic check_value(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int exp);
    cmpCount++;
    if (got != exp) begin
      badCount++;
      $display("wrong value at %0t: saw %0d pulses, expected %0d", $time, got, exp);
    end
  endtask

  task automatic read_check(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    reg_read(a, d);
    check_value(d, exp);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    badCount = 0;
    cmpCount = 0;
    irqSecondSeen = 0;
    irqFirstSeen = 0;
    cycles = 0;
    edgeCodes = '{tcc_pkg::EDGE_FALL, tcc_pkg::EDGE_RISE, tcc_pkg::EDGE_BOTH};
    edgeIrqs = '{1, 1, 2};
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    // Reset values and plain register access
    read_check(tcc_pkg::ADDR_CC_SECOND, 16'h0000);
    read_check(tcc_pkg::ADDR_MODE, 16'h0000);
    read_check(16'hFF40, 16'h0000);
    reg_write(tcc_pkg::ADDR_CC_SECOND, 16'hA5C3);
    read_check(tcc_pkg::ADDR_CC_SECOND, 16'hA5C3);
    // Writing 1 to the overflow bit must not set it
    reg_write(tcc_pkg::ADDR_MODE, 16'h0001);
    read_check(tcc_pkg::ADDR_MODE, 16'h0000);
    // Stopped: pin activity neither counts nor requests
    i_tcc_pin_model.set_pin(0, 1'b1, 30);
    i_tcc_pin_model.set_pin(1, 1'b1, 30);
    i_tcc_pin_model.set_pin(0, 1'b0, 30);
    i_tcc_pin_model.set_pin(1, 1'b0, 30);
    check_count(irqSecondSeen + irqFirstSeen, 0);
    read_check(tcc_pkg::ADDR_COUNT, 16'h0000);
    // Second register zero: request on the first step away from zero
    reg_write(tcc_pkg::ADDR_CC_SECOND, 16'h0000);
    reg_write(tcc_pkg::ADDR_CC_FIRST, 16'h8000);
    reg_write(tcc_pkg::ADDR_MODE, mode_word(tcc_pkg::MODE_FREE));
    repeat (12) @(posedge clk);
    check_count(irqSecondSeen, 1);
    check_value({15'h0000, timerOutputPin}, 16'h0001);
    reg_read(tcc_pkg::ADDR_COUNT, valA);
    repeat (20) @(posedge clk);
    reg_read(tcc_pkg::ADDR_COUNT, valB);
    check_value({15'h0000, valB > valA}, 16'h0001);
    // Clear on input edge: count restarts from zero
    reg_write(tcc_pkg::ADDR_MODE, mode_word(tcc_pkg::MODE_STOP));
    read_check(tcc_pkg::ADDR_COUNT, 16'h0000);
    reg_write(tcc_pkg::ADDR_PRESCALE, 16'h0010);
    reg_write(tcc_pkg::ADDR_MODE, mode_word(tcc_pkg::MODE_CLR_EDGE));
    repeat (200) @(posedge clk);
    i_tcc_pin_model.set_pin(0, 1'b1, 4);
    reg_read(tcc_pkg::ADDR_COUNT, valA);
    check_value({15'h0000, valA < 16'h0010}, 16'h0001);
    i_tcc_pin_model.set_pin(0, 1'b0, 4);
    // Clear on first match: the second match repeats every short period
    reg_write(tcc_pkg::ADDR_MODE, mode_word(tcc_pkg::MODE_STOP));
    reg_write(tcc_pkg::ADDR_CC_FIRST, 16'h0005);
    reg_write(tcc_pkg::ADDR_CC_SECOND, 16'h0003);
    irqSecondSeen = 0;
    irqFirstSeen = 0;
    reg_write(tcc_pkg::ADDR_MODE, mode_word(tcc_pkg::MODE_CLR_MATCH));
    repeat (48) @(posedge clk);
    check_value({15'h0000, irqSecondSeen >= 3}, 16'h0001);
    check_value({15'h0000, irqFirstSeen >= 3}, 16'h0001);
    // Capture role on each legal edge selection
    for (int i = 0; i < 3; i++) begin
      reg_write(tcc_pkg::ADDR_MODE, mode_word(tcc_pkg::MODE_STOP));
      reg_write(tcc_pkg::ADDR_CC_FIRST, 16'h8000);
      reg_write(tcc_pkg::ADDR_CC_CTRL, 16'h0004);
      reg_write(tcc_pkg::ADDR_PRESCALE, {8'h00, 2'h0, edgeCodes[i], 4'h0});
      irqSecondSeen = 0;
      reg_write(tcc_pkg::ADDR_MODE, mode_word(tcc_pkg::MODE_FREE));
      i_tcc_pin_model.set_pin(0, 1'b1, 40);
      i_tcc_pin_model.set_pin(0, 1'b0, 40);
      check_count(irqSecondSeen, edgeIrqs[i]);
      reg_read(tcc_pkg::ADDR_CC_SECOND, valA);
      check_value({15'h0000, valA != 16'h0000}, 16'h0001);
    end
    // Compare role ignores the capture trigger; first request pulses on second-pin fall
    reg_write(tcc_pkg::ADDR_MODE, mode_word(tcc_pkg::MODE_STOP));
    reg_write(tcc_pkg::ADDR_CC_CTRL, 16'h0001);
    reg_write(tcc_pkg::ADDR_CC_SECOND, 16'h7777);
    // Timing bit set: the first-input valid edge inverts the output too
    reg_write(tcc_pkg::ADDR_MODE, mode_word(tcc_pkg::MODE_FREE) | 16'h0002);
    valB = {15'h0000, timerOutputPin};
    irqSecondSeen = 0;
    irqFirstSeen = 0;
    i_tcc_pin_model.set_pin(0, 1'b1, 40);
    check_value({15'h0000, timerOutputPin}, valB ^ 16'h0001);
    i_tcc_pin_model.set_pin(0, 1'b0, 40);
    check_count(irqSecondSeen, 0);
    i_tcc_pin_model.set_pin(1, 1'b1, 40);
    i_tcc_pin_model.set_pin(1, 1'b0, 40);
    check_count(irqFirstSeen, 1);
    read_check(tcc_pkg::ADDR_CC_SECOND, 16'h7777);
    // Leave the timer stopped, as software must before any clock-stopping mode
    reg_write(tcc_pkg::ADDR_MODE, mode_word(tcc_pkg::MODE_STOP));
    read_check(tcc_pkg::ADDR_COUNT, 16'h0000);
    tally_and_finish();
  end
endmodule // tb
